// ==== core/slr_top.sv ====
// serial register read path and ambient light control of the sensor
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// How it works
// - idle without measurement demand, bus stays alive
// - emitter sink off whenever in standby
// - read returns register at the pointer
// - stop or repeated start both accepted
// - pointer advances after every read byte
// - answer 26h for write, 27h for read
// - result high byte 85h, low 86h
// - standard mode uses a fixed 100 ms frame
// - single conversion lasts 300 us, rest idle
// - average programmed count of conversions, up to 128
// - standard result only at frame end
// - continuous mode runs conversions back to back
module slr_top #(
    parameter int unsigned CONV_CYC_P  = slr_pkg::CONV_CYC,
    parameter int unsigned FRAME_CYC_P = slr_pkg::FRAME_CYC
) (
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic        SCL,
    input  wire logic        SDA_I,
    output var  logic        SDA_O,
    output var  logic        SDA_OE,
    input  wire logic [15:0] AMB_SAMPLE,
    output var  logic        STANDBY,
    output var  logic        LED_SINK_EN
);
    import slr_pkg::*;

    slr_top_s r;
    slr_top_s n;
    slr_if    tif ();

    function automatic logic [7:0] reg_read(input slr_top_s s);
        unique case (s.ptr)
            REG_CMD:     return s.cmd;
            REG_LED_CUR: return s.led_cur;
            REG_AMB_PAR: return s.amb_par;
            REG_AMB_HI:  return s.res[15:8];
            REG_AMB_LO:  return s.res[7:0];
            default:     return 8'h00;
        endcase
    endfunction

    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [7:0] rd_byte;
    assign rise    = !r.scl_q && SCL;
    assign fall    = r.scl_q && !SCL;
    // start and stop only count while the clock line is high
    assign start   = r.scl_q && SCL && r.sda_q && !SDA_I;
    assign stop    = r.scl_q && SCL && !r.sda_q && SDA_I;
    assign rd_byte = reg_read(r);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = r;
        n.scl_q   = SCL;
        n.sda_q   = SDA_I;
        n.standby = !(r.cmd[CMD_AMB_BIT] || r.cmd[CMD_PRX_BIT]);
        // emitter sink follows a live proximity demand only
        n.led_en  = r.cmd[CMD_PRX_BIT];
        if (tif.result_vld) begin
            n.res = tif.result;
        end
        if (start) begin
            n.st     = ST_DEV;
            n.bitcnt = 4'h0;
            n.sda_oe = 1'b0;
        end else if (stop) begin
            n.st     = ST_IDLE;
            n.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                ST_IDLE: begin
                end
                ST_DEV, ST_RCV: begin
                    if (rise) begin
                        n.shreg  = {r.shreg[6:0], SDA_I};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (fall && r.bitcnt == 4'h8) begin
                        n.bitcnt = 4'h0;
                        if (r.st == ST_DEV) begin
                            if (r.shreg == ADDR_WR || r.shreg == ADDR_RD) begin
                                n.sda_oe = 1'b1;
                                n.rw     = r.shreg[0];
                                n.first  = !r.shreg[0];
                                n.st     = ST_DACK;
                            end else begin
                                n.st = ST_IDLE;
                            end
                        end else begin
                            n.sda_oe = 1'b1;
                            n.st     = ST_RACK;
                            n.first  = 1'b0;
                            if (r.first) begin
                                n.ptr = r.shreg;
                            end else begin
                                unique case (r.ptr)
                                    REG_CMD:     n.cmd     = r.shreg;
                                    REG_LED_CUR: n.led_cur = r.shreg;
                                    REG_AMB_PAR: n.amb_par = r.shreg;
                                    default: begin
                                    end
                                endcase
                                n.ptr = r.ptr + 8'h01;
                            end
                        end
                    end
                end
                ST_DACK, ST_RACK, ST_MACK: begin
                    if (rise && r.st == ST_MACK) begin
                        n.nack = SDA_I;
                    end else if (fall) begin
                        if ((r.st == ST_DACK && r.rw) ||
                            (r.st == ST_MACK && !r.nack)) begin
                            n.shreg  = rd_byte;
                            n.sda_oe = !rd_byte[7];
                            n.bitcnt = 4'h0;
                            n.st     = ST_SEND;
                        end else begin
                            n.sda_oe = 1'b0;
                            // a refused byte ends the read until a start
                            n.st     = (r.st == ST_MACK) ? ST_IDLE : ST_RCV;
                        end
                    end
                end
                ST_SEND: begin
                    if (fall) begin
                        if (r.bitcnt == 4'h7) begin
                            n.sda_oe = 1'b0;
                            n.ptr    = r.ptr + 8'h01;
                            n.nack   = 1'b1;
                            n.st     = ST_MACK;
                        end else begin
                            n.shreg  = {r.shreg[6:0], 1'b0};
                            n.sda_oe = !r.shreg[6];
                            n.bitcnt = r.bitcnt + 4'h1;
                        end
                    end
                end
                default: n.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            r <= '{st: ST_IDLE, bitcnt: 4'h0, shreg: 8'h00, rw: 1'b0,
                   first: 1'b0, nack: 1'b1, ptr: 8'h00, scl_q: 1'b1,
                   sda_q: 1'b1, sda_oe: 1'b0, cmd: CMD_RST,
                   led_cur: LED_CUR_RST, amb_par: AMB_PAR_RST,
                   res: RES_RST, standby: 1'b1, led_en: 1'b0};
        end else begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign tif.run      = r.cmd[CMD_AMB_BIT];
    assign tif.cont     = r.amb_par[PAR_CONT_BIT];
    assign tif.avg_log2 = r.amb_par[PAR_AVG_LSB +: PAR_AVG_W];
    assign tif.sample   = AMB_SAMPLE;

    slr_timer #(
        .CONV_CYC_P  (CONV_CYC_P),
        .FRAME_CYC_P (FRAME_CYC_P)
    ) u_timer (
        .clk (CLOCK),
        .rst (SYS_RST),
        .bus (tif)
    );

    // open drain: only ever pulls low
    assign SDA_O       = 1'b0;
    assign SDA_OE      = r.sda_oe;
    assign STANDBY     = r.standby;
    assign LED_SINK_EN = r.led_en;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    sequence seq_addr_done;
        r.st == ST_DEV && fall && r.bitcnt == 4'h8 && !start && !stop;
    endsequence
    sequence seq_byte_sent;
        r.st == ST_SEND && fall && r.bitcnt == 4'h7 && !start && !stop;
    endsequence

    AST_STANDBY: assert property (
        ##1 STANDBY == !($past(r.cmd[CMD_AMB_BIT]) ||
                         $past(r.cmd[CMD_PRX_BIT])))
        else $error("standby does not follow measurement demand");
    AST_LED_OFF: assert property (STANDBY |-> !LED_SINK_EN)
        else $error("emitter sink active in standby");
    AST_ADDR_ACK: assert property (
        seq_addr_done ##0 (r.shreg == ADDR_WR || r.shreg == ADDR_RD)
        |=> SDA_OE && r.st == ST_DACK)
        else $error("own address not acknowledged");
    AST_ADDR_IGN: assert property (
        seq_addr_done ##0 (r.shreg != ADDR_WR && r.shreg != ADDR_RD)
        |=> !SDA_OE && r.st == ST_IDLE)
        else $error("foreign address answered");
    AST_PTR_SET: assert property (
        (r.st == ST_RCV && r.first && fall && r.bitcnt == 4'h8
         && !start && !stop) |=> r.ptr == $past(r.shreg) && SDA_OE)
        else $error("pointer not loaded from register byte");
    AST_TX_DATA: assert property (
        (r.st == ST_DACK && r.rw && fall && !start && !stop)
        |=> r.shreg == $past(rd_byte) && SDA_OE == !$past(rd_byte[7]))
        else $error("read byte not taken from pointed register");
    AST_PTR_INC: assert property (
        seq_byte_sent |=> r.ptr == $past(r.ptr) + 8'h01 ##1
        r.ptr == $past(r.ptr))
        else $error("pointer not advanced once after read byte");
    AST_RSTART: assert property (start |=> r.st == ST_DEV && !SDA_OE)
        else $error("repeated start not accepted");
    AST_RESULT: assert property (
        tif.result_vld |=> r.res == $past(tif.result))
        else $error("result register not updated");
endmodule // slr_top
`default_nettype wire

// ==== core/slr_pkg.sv ====
// shared constants and types for the sensor bus read and light timing block
package slr_pkg;
    // bus address bytes, read/write bit included
    localparam logic [7:0] ADDR_WR = 8'h26;
    localparam logic [7:0] ADDR_RD = 8'h27;
    // register map
    localparam logic [7:0] REG_CMD     = 8'h80;
    localparam logic [7:0] REG_LED_CUR = 8'h83;
    localparam logic [7:0] REG_AMB_PAR = 8'h84;
    localparam logic [7:0] REG_AMB_HI  = 8'h85;
    localparam logic [7:0] REG_AMB_LO  = 8'h86;
    // field positions
    localparam int CMD_PRX_BIT  = 1;
    localparam int CMD_AMB_BIT  = 2;
    localparam int PAR_CONT_BIT = 7;
    localparam int PAR_AVG_LSB  = 0;
    localparam int PAR_AVG_W    = 3;
    // reset values
    localparam logic [7:0]  CMD_RST     = 8'h00;
    localparam logic [7:0]  LED_CUR_RST = 8'h00;
    localparam logic [7:0]  AMB_PAR_RST = 8'h00;
    localparam logic [15:0] RES_RST     = 16'h0000;
    // timing
    localparam int CLK_MHZ        = 200;
    localparam int CONV_TIME_US   = 300;
    localparam int FRAME_TIME_MS  = 100;
    localparam int CONV_CYC       = CONV_TIME_US * CLK_MHZ;
    localparam int FRAME_CYC      = FRAME_TIME_MS * 1000 * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV  = 3'h1,
        ST_DACK = 3'h3,
        ST_RCV  = 3'h2,
        ST_RACK = 3'h6,
        ST_SEND = 3'h7,
        ST_MACK = 3'h5
    } slr_bus_e;

    typedef enum logic [1:0] {
        TS_IDLE = 2'h0,
        TS_CONV = 2'h1,
        TS_WAIT = 2'h3
    } slr_tim_e;

    typedef struct packed {
        slr_bus_e    st;
        logic [3:0]  bitcnt;
        logic [7:0]  shreg;
        logic        rw;
        logic        first;
        logic        nack;
        logic [7:0]  ptr;
        logic        scl_q;
        logic        sda_q;
        logic        sda_oe;
        logic [7:0]  cmd;
        logic [7:0]  led_cur;
        logic [7:0]  amb_par;
        logic [15:0] res;
        logic        standby;
        logic        led_en;
    } slr_top_s;

    typedef struct packed {
        slr_tim_e    st;
        logic [15:0] cnt;
        logic [24:0] frame;
        logic [7:0]  nconv;
        logic [22:0] acc;
        logic [15:0] result;
        logic        vld;
    } slr_tim_s;
endpackage

// ==== core/slr_if.sv ====
// link between the register side and the light conversion timer
`timescale 1ns/1ps
`default_nettype none
interface slr_if;
    logic        run;
    logic        cont;
    logic [2:0]  avg_log2;
    logic [15:0] sample;
    logic [15:0] result;
    logic        result_vld;
    modport ctrl (output run, cont, avg_log2, sample,
                  input result, result_vld);
    modport conv (input run, cont, avg_log2, sample,
                  output result, result_vld);
endinterface
`default_nettype wire

// ==== core/slr_timer.sv ====
// ambient light conversion timing and averaging
`timescale 1ns/1ps
`default_nettype none
module slr_timer #(
    parameter int unsigned CONV_CYC_P  = slr_pkg::CONV_CYC,
    parameter int unsigned FRAME_CYC_P = slr_pkg::FRAME_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    slr_if.conv       bus
);
    import slr_pkg::*;

    slr_tim_s r;
    slr_tim_s n;

    function automatic logic [15:0] avg_of(input logic [22:0] acc,
                                           input logic [2:0]  lg);
        return 16'(acc >> lg);
    endfunction

    logic       last_conv;
    logic       set_done;
    logic [22:0] acc_add;
    assign last_conv = (r.cnt == 16'(CONV_CYC_P - 1));
    assign set_done  = ((r.nconv + 8'h01) == (8'h01 << bus.avg_log2));
    assign acc_add   = r.acc + 23'(bus.sample);

    always_comb begin
        n = r;
        n.vld = 1'b0;
        unique case (r.st)
            TS_IDLE: begin
                if (bus.run) begin
                    n.st    = TS_CONV;
                    n.cnt   = 16'h0000;
                    n.frame = 25'h0000000;
                    n.nconv = 8'h00;
                    n.acc   = 23'h000000;
                end
            end
            TS_CONV: begin
                n.frame = r.frame + 25'h0000001;
                n.cnt   = r.cnt + 16'h0001;
                if (last_conv) begin
                    n.cnt   = 16'h0000;
                    n.acc   = acc_add;
                    n.nconv = r.nconv + 8'h01;
                    if (set_done) begin
                        n.nconv = 8'h00;
                        if (bus.cont) begin
                            n.result = avg_of(acc_add, bus.avg_log2);
                            n.vld    = 1'b1;
                            n.acc    = 23'h000000;
                            n.frame  = 25'h0000000;
                        end else begin
                            n.st = TS_WAIT;
                        end
                    end
                end
            end
            TS_WAIT: begin
                n.frame = r.frame + 25'h0000001;
                // a set finishing early still waits out the frame
                if (r.frame == 25'(FRAME_CYC_P - 1)) begin
                    n.result = avg_of(r.acc, bus.avg_log2);
                    n.vld    = 1'b1;
                    n.acc    = 23'h000000;
                    n.frame  = 25'h0000000;
                    n.cnt    = 16'h0000;
                    n.st     = TS_CONV;
                end
            end
            default: n.st = TS_IDLE;
        endcase
        if (!bus.run) begin
            n.st = TS_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '{st: TS_IDLE, cnt: 16'h0000, frame: 25'h0000000,
                   nconv: 8'h00, acc: 23'h000000, result: 16'h0000,
                   vld: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign bus.result     = r.result;
    assign bus.result_vld = r.vld;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_STD_FRAME: assert property (
        (r.vld && !$past(bus.cont)) |-> $past(r.frame) ==
            25'(FRAME_CYC_P - 1))
        else $error("standard result published before frame end");
    AST_CONT_NOGAP: assert property (
        (bus.cont && bus.run && $past(bus.cont) && $past(bus.run)
         && $past(r.st) == TS_CONV) |-> r.st == TS_CONV)
        else $error("continuous mode left conversion state");
    AST_CONT_PUB: assert property (
        (r.st == TS_CONV && last_conv && set_done && bus.cont && bus.run)
        |=> r.vld)
        else $error("continuous result not published after last conversion");
    AST_CONV_LEN: assert property (
        (r.st == TS_CONV && last_conv && bus.run) |=> r.cnt == 16'h0000)
        else $error("conversion length counter did not restart");
endmodule // slr_timer
`default_nettype wire

// ==== test/slr_host.sv ====
// host bus controller model that reads and writes sensor registers
`timescale 1ns/1ps
`default_nettype none
module slr_host (
    input  wire logic clk,
    input  wire logic sda_in,
    output var  logic scl,
    output var  logic sda_pull
);
    // eight clocks per half period keeps the device sampler well ahead
    localparam int HALF = 8;
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // works from idle and as a repeated start after an acked byte
    task automatic bus_start();
        tick(HALF / 2);
        sda_pull = 1'b0;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        sda_pull = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask
    task automatic bus_stop();
        tick(HALF / 2);
        sda_pull = 1'b1;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        sda_pull = 1'b0;
        tick(HALF);
    endtask
    // data moves only while the clock line is low, never at its edges
    task automatic put_bit(input logic b);
        tick(HALF / 2);
        sda_pull = ~b;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF);
        scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        tick(HALF / 2);
        sda_pull = 1'b0;
        tick(HALF / 2);
        scl = 1'b1;
        tick(HALF / 2);
        b = sda_in;
        tick(HALF / 2);
        scl = 1'b0;
    endtask
    // address bytes 26h and 27h are sent by the caller through here
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic nack;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        get_bit(nack);
        ack = ~nack;
    endtask
    task automatic recv_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            get_bit(b[i]);
        end
        put_bit(last);
    endtask
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
endmodule // slr_host
`default_nettype wire

// ==== test/sensor_bus_read_and_light_timing_test.sv ====
// self-checking bench for the sensor register read path and light timing
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
    num_errors++; $display("mismatch %s expected %0h seen %0h", nm, ex, \
    got); end end
module sensor_bus_read_and_light_timing_test;
    import slr_pkg::*;
    localparam int unsigned CONV = 4;
    localparam int unsigned FRAME = 2000;
    logic        clock;
    logic        sys_rst;
    logic [15:0] amb_sample;
    logic        scl;
    logic        host_pull;
    logic        sda_o;
    logic        sda_oe;
    logic        standby;
    logic        led_en;
    wire logic   sda_i;
    int          num_errors;
    int          tests_run;
    logic [7:0]  cmd_m;
    logic [7:0]  led_m;
    logic [7:0]  par_m;
    logic [15:0] res_m;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  a;
    logic        ak;
    ////////////////////////////////////////////////////////////////////////
    // wired-and line with pull-up: either side pulls low
    assign sda_i = ~(sda_oe | host_pull);
    slr_top #(.CONV_CYC_P(CONV), .FRAME_CYC_P(FRAME)) u_dut (
        .CLOCK(clock), .SYS_RST(sys_rst), .SCL(scl), .SDA_I(sda_i),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .AMB_SAMPLE(amb_sample),
        .STANDBY(standby), .LED_SINK_EN(led_en));
    slr_host u_host (.clk(clock), .sda_in(sda_i), .scl(scl),
        .sda_pull(host_pull));
    initial clock = 1'b0;
    always #2.5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_reg(input logic [7:0] ad);
        case (ad)
            REG_CMD:     return cmd_m;
            REG_LED_CUR: return led_m;
            REG_AMB_PAR: return par_m;
            REG_AMB_HI:  return res_m[15:8];
            REG_AMB_LO:  return res_m[7:0];
            default:     return 8'h00;
        endcase
    endfunction
    task automatic send_chk(input logic [7:0] b);
        logic k;
        u_host.send_byte(b, k);
        `CHK("byte_ack", 1'b1, k)
    endtask
    task automatic set_ptr(input logic [7:0] ad);
        u_host.bus_start();
        send_chk(ADDR_WR);
        send_chk(ad);
    endtask
    task automatic reg_write(input logic [7:0] ad, input logic [7:0] d);
        set_ptr(ad);
        send_chk(d);
        u_host.bus_stop();
        repeat (3) @(negedge clock);
    endtask
    // pointer set without data, then a two byte read
    task automatic read_two(input logic [7:0] ad, input logic set,
                            input logic rep);
        if (set) begin
            set_ptr(ad);
            if (!rep) begin
                u_host.bus_stop();
            end
        end
        u_host.bus_start();
        send_chk(ADDR_RD);
        u_host.recv_byte(1'b0, b0);
        u_host.recv_byte(1'b1, b1);
        u_host.bus_stop();
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        num_errors++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        num_errors = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        amb_sample = 16'h0000;
        cmd_m = CMD_RST;
        led_m = LED_CUR_RST;
        par_m = AMB_PAR_RST;
        res_m = RES_RST;
        a = 8'($urandom(32));
        repeat (3) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        `CHK("standby", 1'b1, standby)
        `CHK("led_sink", 1'b0, led_en)
        `CHK("sda_oe", 1'b0, sda_oe)
        `CHK("sda_o", 1'b0, sda_o)
        // foreign addresses must get no acknowledge
        for (int i = 0; i < 4; i++) begin
            a = 8'($urandom);
            if (a[7:1] == 7'h13) a = 8'h4E;
            u_host.bus_start();
            u_host.send_byte(a, ak);
            `CHK("foreign_ack", 1'b0, ak)
            u_host.bus_stop();
        end
        led_m = 8'($urandom);
        reg_write(REG_LED_CUR, led_m);
        cmd_m = 8'h02;
        reg_write(REG_CMD, cmd_m);
        `CHK("standby", 1'b0, standby)
        `CHK("led_sink", 1'b1, led_en)
        cmd_m = 8'h00;
        reg_write(REG_CMD, cmd_m);
        `CHK("standby", 1'b1, standby)
        `CHK("led_sink", 1'b0, led_en)
        // repeated start, then stop, then a kept pointer
        read_two(REG_CMD, 1'b1, 1'b1);
        `CHK("rd_cmd", exp_reg(REG_CMD), b0)
        `CHK("rd_next", exp_reg(8'h81), b1)
        read_two(8'h82, 1'b1, 1'b0);
        `CHK("rd_gap", exp_reg(8'h82), b0)
        `CHK("rd_led", exp_reg(REG_LED_CUR), b1)
        read_two(8'h00, 1'b0, 1'b0);
        `CHK("rd_par", exp_reg(REG_AMB_PAR), b0)
        `CHK("rd_hi", exp_reg(REG_AMB_HI), b1)
        // standard frame: 128 conversions end long before the frame
        amb_sample = 16'($urandom);
        par_m = 8'h07;
        reg_write(REG_AMB_PAR, par_m);
        cmd_m = 8'h04;
        reg_write(REG_CMD, cmd_m);
        `CHK("standby", 1'b0, standby)
        read_two(REG_AMB_HI, 1'b1, 1'b0);
        `CHK("early_hi", exp_reg(REG_AMB_HI), b0)
        `CHK("early_lo", exp_reg(REG_AMB_LO), b1)
        repeat (FRAME) @(negedge clock);
        res_m = amb_sample;
        read_two(REG_AMB_HI, 1'b1, 1'b0);
        `CHK("frame_hi", exp_reg(REG_AMB_HI), b0)
        `CHK("frame_lo", exp_reg(REG_AMB_LO), b1)
        // continuous mode publishes well inside one frame time
        for (int k = 0; k < 3; k++) begin
            cmd_m = 8'h00;
            reg_write(REG_CMD, cmd_m);
            `CHK("standby", 1'b1, standby)
            par_m = {1'b1, 4'h0, 3'($urandom_range(4))};
            reg_write(REG_AMB_PAR, par_m);
            amb_sample = 16'($urandom);
            cmd_m = 8'h04;
            reg_write(REG_CMD, cmd_m);
            res_m = amb_sample;
            read_two(REG_AMB_HI, 1'b1, 1'b1);
            `CHK("cont_hi", exp_reg(REG_AMB_HI), b0)
            `CHK("cont_lo", exp_reg(REG_AMB_LO), b1)
        end
        print_verdict();
    end
endmodule // sensor_bus_read_and_light_timing_test
`default_nettype wire
